// ### logic/nfec_consts.svh
`ifndef NFEC_CONSTS_SVH
`define NFEC_CONSTS_SVH
// register offsets of the controller's own port
`define NFEC_REG_CTRL     4'h0
`define NFEC_REG_SECTOR   4'h1
`define NFEC_REG_ADDR     4'h2
`define NFEC_REG_DATA     4'h3
`define NFEC_REG_STATUS   4'h4
`define NFEC_REG_RDATA    4'h5
// ctrl command codes (written to ctrl low bits)
`define NFEC_OP_SECT_ERASE 4'h1
`define NFEC_OP_ADD_SECTOR 4'h2
`define NFEC_OP_SUSPEND    4'h3
`define NFEC_OP_RESUME     4'h4
`define NFEC_OP_READ       4'h5
`define NFEC_OP_RESET      4'h6
`define NFEC_OP_PROGRAM    4'h7
`define NFEC_OP_AUTOSEL    4'h8
`define NFEC_OP_SECR_ENTER 4'h9
`define NFEC_OP_SECR_EXIT  4'ha
`define NFEC_OP_BYP_ENTER  4'hb
`define NFEC_OP_BYP_EXIT   4'hc
`define NFEC_OP_BYP_PROG   4'hd
`define NFEC_OP_BUF_START  4'he
`define NFEC_OP_BUF_COMMIT 4'hf
// unlock addresses and command data
`define NFEC_UNLOCK_A1    11'h555
`define NFEC_UNLOCK_A2    11'h2aa
`define NFEC_UNLOCK_D1    8'haa
`define NFEC_UNLOCK_D2    8'h55
`define NFEC_CMD_SETUP    8'h80
`define NFEC_CMD_SERASE   8'h30
`define NFEC_CMD_SUSPEND  8'hb0
`define NFEC_CMD_RESUME   8'h30
`define NFEC_CMD_RESET    8'hf0
`define NFEC_CMD_PROG     8'ha0
`define NFEC_CMD_AUTOSEL  8'h90
`define NFEC_CMD_SECR     8'h88
`define NFEC_CMD_BYPASS   8'h20
`define NFEC_CMD_EXIT1    8'h90
`define NFEC_CMD_EXIT2    8'h00
`define NFEC_CMD_BUFLOAD  8'h25
`define NFEC_CMD_BUFCOMMIT 8'h29
// status register bit positions
`define NFEC_ST_BUSY      0
`define NFEC_ST_WIN_EXP   1
`define NFEC_ST_POLL      2
`define NFEC_ST_TOGGLE    3
`define NFEC_ST_ESTOG     4
`define NFEC_ST_RVALID    5
// timing: window in ns, cycle in ns
`define NFEC_WINDOW_NS    50000
`define NFEC_CLK_NS       40
`define NFEC_WINDOW_CYC   (`NFEC_WINDOW_NS / `NFEC_CLK_NS)
// pin timing in cycles
`define NFEC_WE_LOW_CYC   3'h2
`define NFEC_RD_CYC       3'h3
`endif

// ### logic/nfec_host.sv
// The plain strobed port and the register addresses are this design's own decisions.
`include "nfec_consts.svh"
// Function
// - erase: five unlock/setup writes, then sector/30
// - extra sectors issued within 50 us
// - hardware reset aborts; erase is reissued whole
// - buffer load: unlock, sector/25, count, pairs
// - commit buffer with 29 at sector
// - load count is locations minus one
module nfec_host #(
  parameter int WINDOW_CYC = `NFEC_WINDOW_CYC  // sector window in cycles
) (
  input  wire logic        clk,        // 25 MHz clock
  input  wire logic        arst_n,     // async reset, active low
  input  wire logic [3:0]  reg_addr,   // register address
  input  wire logic [31:0] reg_wdata,  // register write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic [31:0]      reg_rdata,  // read data, cycle after strobe
  output logic [21:0]      f_addr,     // flash address pins
  output logic [15:0]      f_dq_o,     // flash data out
  output logic [15:0]      f_dq_oe,    // data drive enable, one bit copied to all 16
  input  wire logic [15:0] f_dq_i,     // flash data in
  output logic             f_ce_n,     // chip enable
  output logic             f_we_n,     // write strobe
  output logic             f_oe_n,     // output enable
  output logic             f_reset_n   // hardware reset to flash
);
  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dq_s1_q <= 16'h0;
      dq_s2_q <= 16'h0;
    end
    else
    begin
      dq_s1_q <= f_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [21:0] sector_q;   // sector_select_address
  logic [21:0] addr_q;     // program_target_address
  logic [15:0] data_q;     // program_write_value or load_count_minus_one
  logic        rst_q;      // flash reset drive
  logic        win_exp_q;  // window expired, host view
  logic [31:0] rdata_q;

  wire wr_ctrl   = reg_wr && (reg_addr == `NFEC_REG_CTRL);
  wire [3:0] op  = reg_wdata[3:0];
  wire rst_cmd   = wr_ctrl && reg_wdata[31];

  ////////////////////////////////////////////////////////////////////////////
  // command sequence table: up to six cycles per op
  logic [2:0]            n_cyc;
  nfec_pkg::nfec_cyc_t   seq [6];
  logic [3:0]            op_q;
  logic [2:0]            idx_q;
  nfec_pkg::nfec_st_t    st_q;
  logic                  start;
  logic                  pc_busy;
  logic                  pc_done;
  logic [15:0]           pc_rdata;
  logic                  dq_oe1;     // one enable from the pin cycle
  wire [21:0] a555 = {11'h0, `NFEC_UNLOCK_A1};
  wire [21:0] a2aa = {11'h0, `NFEC_UNLOCK_A2};
  wire nfec_pkg::nfec_cyc_t u1 = '{1'b1, a555, {8'h0, `NFEC_UNLOCK_D1}};
  wire nfec_pkg::nfec_cyc_t u2 = '{1'b1, a2aa, {8'h0, `NFEC_UNLOCK_D2}};

  // sequences; unlisted slots hold a harmless read
  always_comb
  begin
    n_cyc = 3'h1;
    for (int i = 0; i < 6; i++)
      seq[i] = '{1'b0, addr_q, 16'h0};
    case (op_q)
      `NFEC_OP_SECT_ERASE:
      begin
        n_cyc  = 3'h6;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_SETUP}};
        seq[3] = u1;
        seq[4] = u2;
        seq[5] = '{1'b1, sector_q, {8'h0, `NFEC_CMD_SERASE}};
      end
      `NFEC_OP_ADD_SECTOR:
        seq[0] = '{1'b1, sector_q, {8'h0, `NFEC_CMD_SERASE}};
      `NFEC_OP_SUSPEND:
        seq[0] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_SUSPEND}};
      `NFEC_OP_RESUME:
        seq[0] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_RESUME}};
      `NFEC_OP_RESET:
        seq[0] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_RESET}};
      `NFEC_OP_PROGRAM:
      begin
        n_cyc  = 3'h4;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_PROG}};
        seq[3] = '{1'b1, addr_q, data_q};
      end
      `NFEC_OP_AUTOSEL:
      begin
        n_cyc  = 3'h3;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_AUTOSEL}};
      end
      `NFEC_OP_SECR_ENTER:
      begin
        n_cyc  = 3'h3;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_SECR}};
      end
      `NFEC_OP_SECR_EXIT:
      begin
        n_cyc  = 3'h4;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_EXIT1}};
        seq[3] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_EXIT2}};
      end
      `NFEC_OP_BYP_ENTER:
      begin
        n_cyc  = 3'h3;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, a555, {8'h0, `NFEC_CMD_BYPASS}};
      end
      `NFEC_OP_BYP_PROG:
      begin
        n_cyc  = 3'h2;
        seq[0] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_PROG}};
        seq[1] = '{1'b1, addr_q, data_q};
      end
      `NFEC_OP_BYP_EXIT:
      begin
        n_cyc  = 3'h2;
        seq[0] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_EXIT1}};
        seq[1] = '{1'b1, addr_q, {8'h0, `NFEC_CMD_EXIT2}};
      end
      `NFEC_OP_BUF_START:
      begin
        n_cyc  = 3'h4;
        seq[0] = u1;
        seq[1] = u2;
        seq[2] = '{1'b1, sector_q, {8'h0, `NFEC_CMD_BUFLOAD}};
        seq[3] = '{1'b1, sector_q, data_q};  // software writes count-1
      end
      `NFEC_OP_BUF_COMMIT:
        seq[0] = '{1'b1, sector_q, {8'h0, `NFEC_CMD_BUFCOMMIT}};
      default:
        seq[0] = '{1'b0, addr_q, 16'h0};  // plain read, also buffer data via program
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // window timer: restarts at each erase-write end, flags expiry
  logic [$clog2(WINDOW_CYC+1)-1:0] win_cnt_q;
  logic                            win_run_q;
  wire erase_wr_done = pc_done && st_q == nfec_pkg::NFEC_S_WAIT && idx_q == n_cyc - 3'h1
                       && (op_q == `NFEC_OP_SECT_ERASE || op_q == `NFEC_OP_ADD_SECTOR);
  wire win_end       = win_run_q && (win_cnt_q == '0);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_cnt_q <= '0;
      win_run_q <= 1'b0;
      win_exp_q <= 1'b0;
    end
    else if (erase_wr_done)
    begin
      win_cnt_q <= ($clog2(WINDOW_CYC+1))'(WINDOW_CYC - 1);
      win_run_q <= 1'b1;
      win_exp_q <= 1'b0;
    end
    else if (win_end)
    begin
      win_run_q <= 1'b0;
      win_exp_q <= 1'b1;  // later additions may be lost
    end
    else if (win_run_q)
      win_cnt_q <= win_cnt_q - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: issues one flash cycle at a time
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q  <= nfec_pkg::NFEC_S_IDLE;
      op_q  <= 4'h0;
      idx_q <= 3'h0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_q <= rst_cmd;  // pulse of reset aborts erase
      case (st_q)
        nfec_pkg::NFEC_S_IDLE:
          if (wr_ctrl && !rst_cmd)
          begin
            op_q  <= op;
            idx_q <= 3'h0;
            st_q  <= nfec_pkg::NFEC_S_ISSUE;
          end
        nfec_pkg::NFEC_S_ISSUE:
          st_q <= nfec_pkg::NFEC_S_WAIT;
        nfec_pkg::NFEC_S_WAIT:
          if (pc_done)
          begin
            if (idx_q == n_cyc - 3'h1)
              st_q <= nfec_pkg::NFEC_S_IDLE;
            else
            begin
              idx_q <= idx_q + 3'h1;
              st_q  <= nfec_pkg::NFEC_S_ISSUE;
            end
          end
        default:
          st_q <= nfec_pkg::NFEC_S_IDLE;
      endcase
    end
  end
  assign start = (st_q == nfec_pkg::NFEC_S_ISSUE);

  nfec_pin_cycle u_pc (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   (start),
    .cyc     (seq[idx_q]),
    .busy    (pc_busy),
    .done    (pc_done),
    .rdata   (pc_rdata),
    .f_addr  (f_addr),
    .f_dq_o  (f_dq_o),
    .f_dq_oe (dq_oe1),
    .f_dq_i  (dq_s2_q),
    .f_ce_n  (f_ce_n),
    .f_we_n  (f_we_n),
    .f_oe_n  (f_oe_n)
  );
  assign f_dq_oe   = {16{dq_oe1}};
  assign f_reset_n = ~rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and read port
  wire [31:0] status_w = {26'h0,
                          ~pc_busy,
                          pc_rdata[2],        // erase_sector_toggle_bit
                          pc_rdata[6],        // toggle_status_bit
                          pc_rdata[7],        // data_poll_bit
                          pc_rdata[3] | win_exp_q,  // erase_window_expired_flag
                          (st_q != nfec_pkg::NFEC_S_IDLE)};
  wire [31:0] rd_mux = (reg_addr == `NFEC_REG_SECTOR) ? {10'h0, sector_q} :
                       (reg_addr == `NFEC_REG_ADDR)   ? {10'h0, addr_q} :
                       (reg_addr == `NFEC_REG_DATA)   ? {16'h0, data_q} :
                       (reg_addr == `NFEC_REG_STATUS) ? status_w :
                       (reg_addr == `NFEC_REG_RDATA)  ? {16'h0, pc_rdata} :
                       (reg_addr == `NFEC_REG_CTRL)   ? {28'h0, op_q} : 32'h0;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sector_q <= 22'h0;
      addr_q   <= 22'h0;
      data_q   <= 16'h0;
      rdata_q  <= 32'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == `NFEC_REG_SECTOR)
        sector_q <= reg_wdata[21:0];
      if (reg_wr && reg_addr == `NFEC_REG_ADDR)
        addr_q <= reg_wdata[21:0];
      if (reg_wr && reg_addr == `NFEC_REG_DATA)
        data_q <= reg_wdata[15:0];
      if (reg_rd)
        rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;
endmodule : nfec_host

// ### logic/nfec_pin_cycle.sv
`include "nfec_consts.svh"
// drives one read or write bus cycle on the flash pins
module nfec_pin_cycle (
  input  wire logic              clk,       // system clock
  input  wire logic              arst_n,    // async reset
  input  wire logic              start,     // begin a cycle
  input  wire nfec_pkg::nfec_cyc_t cyc,     // cycle content
  output logic                   busy,      // cycle in flight
  output logic                   done,      // pulse at end
  output logic [15:0]            rdata,     // captured read data
  output logic [21:0]            f_addr,    // flash address
  output logic [15:0]            f_dq_o,    // flash data out
  output logic                   f_dq_oe,   // data drive enable
  input  wire logic [15:0]       f_dq_i,    // flash data in (synced)
  output logic                   f_ce_n,    // chip enable
  output logic                   f_we_n,    // write strobe
  output logic                   f_oe_n     // output enable
);
  nfec_pkg::nfec_pst_t st_q;
  logic [2:0]          cnt_q;
  logic                wr_q;
  wire                 cnt_zero = (cnt_q == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing; rising edge of we_n ends the write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q    <= nfec_pkg::NFEC_P_IDLE;
      cnt_q   <= 3'h0;
      wr_q    <= 1'b0;
      f_addr  <= 22'h0;
      f_dq_o  <= 16'h0;
      f_dq_oe <= 1'b0;
      f_ce_n  <= 1'b1;
      f_we_n  <= 1'b1;
      f_oe_n  <= 1'b1;
      rdata   <= 16'h0;
    end
    else
    begin
      case (st_q)
        nfec_pkg::NFEC_P_IDLE:
          if (start)
          begin
            st_q    <= nfec_pkg::NFEC_P_SETUP;
            wr_q    <= cyc.wr;
            f_addr  <= cyc.addr;
            f_dq_o  <= cyc.data;
            f_dq_oe <= cyc.wr;
            f_ce_n  <= 1'b0;
          end
        nfec_pkg::NFEC_P_SETUP:
        begin
          st_q   <= nfec_pkg::NFEC_P_STRB;
          cnt_q  <= wr_q ? `NFEC_WE_LOW_CYC : `NFEC_RD_CYC;
          f_we_n <= ~wr_q;
          f_oe_n <= wr_q;
        end
        nfec_pkg::NFEC_P_STRB:
          if (cnt_zero)
          begin
            st_q   <= nfec_pkg::NFEC_P_HOLD;
            f_we_n <= 1'b1;
            f_oe_n <= 1'b1;
            if (!wr_q)
              rdata <= f_dq_i;
          end
          else
            cnt_q <= cnt_q - 3'h1;
        nfec_pkg::NFEC_P_HOLD:
        begin
          st_q    <= nfec_pkg::NFEC_P_DONE;
          f_ce_n  <= 1'b1;
          f_dq_oe <= 1'b0;
        end
        nfec_pkg::NFEC_P_DONE:
          st_q <= nfec_pkg::NFEC_P_IDLE;
        default:
          st_q <= nfec_pkg::NFEC_P_IDLE;
      endcase
    end
  end

  assign busy = (st_q != nfec_pkg::NFEC_P_IDLE);
  assign done = (st_q == nfec_pkg::NFEC_P_DONE);
endmodule : nfec_pin_cycle

// ### logic/nfec_pkg.sv
package nfec_pkg;
  // one bus cycle to the flash
  typedef struct packed {
    logic        wr;
    logic [21:0] addr;
    logic [15:0] data;
  } nfec_cyc_t;

  typedef enum logic [2:0] {
    NFEC_P_IDLE  = 3'b000,
    NFEC_P_SETUP = 3'b001,
    NFEC_P_STRB  = 3'b010,
    NFEC_P_HOLD  = 3'b011,
    NFEC_P_DONE  = 3'b100
  } nfec_pst_t;

  typedef enum logic [2:0] {
    NFEC_S_IDLE   = 3'b000,
    NFEC_S_ISSUE  = 3'b001,
    NFEC_S_WAIT   = 3'b010,
    NFEC_S_READ   = 3'b011
  } nfec_st_t;
endpackage : nfec_pkg

// ### sim/nfec_flash_model.sv
module nfec_flash_model #(
  parameter int          WIN_NS = 800,     // sector add window
  parameter int          ERS_NS = 20000,   // erase duration
  parameter logic [15:0] MFR_ID = 16'h00c3 // arbitrary maker code
) (
  input  wire logic [21:0] f_addr,    // address pins
  input  wire logic [15:0] f_dq_o,    // data from host
  input  wire logic [15:0] f_dq_oe,   // host drive enable
  output logic      [15:0] f_dq_i,    // data to host
  input  wire logic        f_ce_n,    // chip enable
  input  wire logic        f_we_n,    // write strobe
  input  wire logic        f_oe_n,    // output enable
  input  wire logic        f_reset_n  // hardware reset
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] M_RD = 3'h0, M_WIN = 3'h1, M_ERS = 3'h2;
  localparam logic [2:0] M_SUS = 3'h3, M_BYP = 3'h4, M_SEC = 3'h5;
  logic [2:0]   mode = 3'h0;  // operating mode
  logic [2:0]   st = 3'h0;    // unlock step
  logic [1:0]   bf = 2'h0;    // buffer load state
  logic         pg = 1'b0;    // program data pending
  logic         asel = 1'b0;  // id mode or exit pending
  logic         tgl = 1'b0;   // toggle bits
  logic [127:0] sel = '0;     // sectors queued for erase
  logic [15:0]  rv = 16'h0;   // read value
  logic [15:0]  lastv = 16'h0;
  time          t0 = 0;       // window start

  // released lines show the inverse of the last value
  assign f_dq_i = (!f_ce_n && !f_oe_n) ? rv : ((f_dq_oe & f_dq_o) | (~f_dq_oe & ~lastv));

  ////////////////////////////////////////////////////////////////////
  // advance window and erase by elapsed time
  task automatic upd();
    if (mode == M_WIN && $time - t0 >= WIN_NS) mode = M_ERS;
    if (mode == M_ERS && $time - t0 >= WIN_NS + ERS_NS)
    begin
      mode = M_RD;
      sel  = '0;
    end
  endtask : upd

  // decode one command write
  task automatic cmd(input logic [21:0] fa, input logic [7:0] d);
    logic [10:0] a;
    a = fa[10:0];
    upd();
    if (mode == M_ERS)
      mode = (d == 8'hb0) ? M_SUS : M_ERS;
    else if (mode == M_WIN)
    begin
      if (d == 8'h30) sel[fa[21:15]] = 1'b1;
      if (d == 8'h30) t0 = $time;
      else mode = (d == 8'hb0) ? M_SUS : M_RD;
    end
    else if (pg) pg = 1'b0;
    else if (bf == 2'h1) bf = 2'h2;
    else if (bf != 2'h0 && d == 8'h29) bf = 2'h0;
    else if (asel && d == 8'h00)
    begin
      asel = 1'b0;
      if (mode > M_SUS) mode = M_RD;
    end
    else if (d == 8'hf0)
    begin
      asel = 1'b0;
      st   = 3'h0;
    end
    else if (mode == M_SUS && st == 3'h0 && d == 8'h30)
    begin
      mode = M_ERS;
      t0   = $time - WIN_NS;
    end
    else if (mode == M_BYP)
    begin
      pg   = (d == 8'ha0);
      asel = (d == 8'h90);
    end
    else if (st == 3'h0 || st == 3'h3)
      st = (a == 11'h555 && d == 8'haa) ? st + 3'h1 : 3'h0;
    else if (st == 3'h1 || st == 3'h4)
      st = (a == 11'h2aa && d == 8'h55) ? st + 3'h1 : 3'h0;
    else if (st == 3'h2)
    begin
      st = 3'h0;
      if (d == 8'h25) bf = 2'h1;
      else if (a != 11'h555) st = 3'h0;
      else if (d == 8'h80) st = 3'h3;
      else if (d == 8'h20) mode = M_BYP;
      else if (d == 8'h88) mode = M_SEC;
      else if (d == 8'ha0) pg = 1'b1;
      else if (d == 8'h90) asel = 1'b1;
    end
    else
    begin
      st = 3'h0;
      if (mode == M_RD && d == 8'h30)
      begin
        mode = M_WIN;
        t0   = $time;
        sel  = '0;
        sel[fa[21:15]] = 1'b1;
      end
    end
  endtask : cmd

  ////////////////////////////////////////////////////////////////////
  // commands latch on the rising write strobe
  always @(posedge f_we_n)
    if (!f_ce_n && f_reset_n) cmd(f_addr, f_dq_o[7:0]);

  // hardware reset aborts everything
  always @(negedge f_reset_n)
  begin
    mode = M_RD;
    st   = 3'h0;
    sel  = '0;
    asel = 1'b0;
    pg   = 1'b0;
    bf   = 2'h0;
  end

  // status in queued sectors, else id or array data
  always @(negedge f_oe_n)
  begin
    upd();
    if (mode inside {M_WIN, M_ERS, M_SUS} && sel[f_addr[21:15]])
      rv = {8'h00, mode == M_SUS, tgl & (mode != M_SUS), 2'b00, mode == M_ERS, tgl, 2'b00};
    else if (asel)
      rv = MFR_ID;
    else
      rv = f_addr[15:0] ^ 16'ha5a5;
  end

  // toggle bits flip once per read
  always @(posedge f_oe_n)
  begin
    tgl   = ~tgl;
    lastv = rv;
  end
endmodule : nfec_flash_model

// ### sim/nfec_props.sv
module nfec_props #(
  parameter int WINDOW_CYC = 1250  // window length in cycles
) (
  input wire logic        clk,        // clock
  input wire logic        arst_n,     // async reset
  input wire logic        reg_rd,     // read strobe
  input wire logic [31:0] reg_rdata,  // read data
  input wire logic [21:0] f_addr,     // flash address
  input wire logic [15:0] f_dq_o,     // flash data out
  input wire logic [15:0] f_dq_oe,    // data drive enable
  input wire logic        f_ce_n,     // chip enable
  input wire logic        f_we_n,     // write strobe
  input wire logic        f_oe_n,     // output enable
  input wire logic        f_reset_n   // flash reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////
  // strobe shapes of one pin cycle
  sequence we_pulse_s;
    !f_we_n [*3] ##1 f_we_n;
  endsequence
  sequence oe_pulse_s;
    !f_oe_n [*4] ##1 f_oe_n;
  endsequence

  ////////////////////////////////////////////////////////////////////
  we_width_a : assert property ($fell(f_we_n) |-> we_pulse_s)
    else $error("write strobe width wrong");
  oe_width_a : assert property ($fell(f_oe_n) |-> oe_pulse_s)
    else $error("read strobe width wrong");
  strobe_excl_a : assert property (!(!f_we_n && !f_oe_n))
    else $error("both strobes low");
  ce_frame_a : assert property ((!f_we_n || !f_oe_n) |-> !f_ce_n)
    else $error("strobe without chip enable");
  ce_release_a : assert property ($rose(f_we_n) |-> !f_ce_n ##1 f_ce_n)
    else $error("chip enable release wrong");
  wr_drive_a : assert property (!f_we_n |-> f_dq_oe == 16'hffff)
    else $error("data not driven in write");
  rd_float_a : assert property (!f_oe_n |-> f_dq_oe == 16'h0000)
    else $error("data driven in read");
  wr_stable_a : assert property (!f_we_n && !$fell(f_we_n) |->
    $stable(f_addr) && $stable(f_dq_o))
    else $error("address or data moved in write");
  reset_pulse_a : assert property ($fell(f_reset_n) |=> f_reset_n)
    else $error("reset pulse not one cycle");
  rdata_hold_a : assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule : nfec_props

bind nfec_host nfec_props #(.WINDOW_CYC(WINDOW_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
  .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_reset_n(f_reset_n));

// ### sim/tb_top.sv
`include "nfec_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN_CYC = 20;  // shortened window
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [21:0] f_addr;
  logic [15:0] f_dq_o;
  logic [15:0] f_dq_oe;
  logic [15:0] f_dq_i;
  logic        f_ce_n;
  logic        f_we_n;
  logic        f_oe_n;
  logic        f_reset_n;
  int          n_errors = 0;
  int          total_checks = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  nfec_host #(.WINDOW_CYC(WIN_CYC)) dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i), .f_ce_n(f_ce_n),
    .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_reset_n(f_reset_n));
  nfec_flash_model #(.WIN_NS(WIN_CYC * 40)) m (.f_addr(f_addr), .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i), .f_ce_n(f_ce_n), .f_we_n(f_we_n),
    .f_oe_n(f_oe_n), .f_reset_n(f_reset_n));

  ////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // register port write and read
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask : rd

  // start an operation and poll busy
  task automatic op(input logic [3:0] c);
    logic [31:0] s;
    wr(`NFEC_REG_CTRL, {28'h0000000, c});
    @(posedge clk);
    for (int n = 0; n < 400; n++)
    begin
      rd(`NFEC_REG_STATUS, s);
      if (s[`NFEC_ST_BUSY] === 1'b0) break;
    end
    chk(s[`NFEC_ST_BUSY], 1'b0);
  endtask : op
  task automatic fread(input logic [21:0] a, output logic [31:0] q);
    wr(`NFEC_REG_ADDR, {10'h000, a});
    op(`NFEC_OP_READ);
    rd(`NFEC_REG_RDATA, q);
  endtask : fread

  ////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    logic [31:0] q;
    logic [3:0]  ops [5];
    logic [2:0]  mds [5];
    ops = '{`NFEC_OP_BYP_ENTER, `NFEC_OP_BYP_PROG, `NFEC_OP_BYP_EXIT,
            `NFEC_OP_SECR_ENTER, `NFEC_OP_SECR_EXIT};
    mds = '{3'h4, 3'h4, 3'h0, 3'h5, 3'h0};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wr(4'hf, 32'h000000a5);
    rd(4'hf, q);
    chk(q, 32'h00000000);
    rd(`NFEC_REG_STATUS, q);
    chk(q[`NFEC_ST_BUSY], 1'b0);
    wr(`NFEC_REG_SECTOR, 32'h00018000);
    op(`NFEC_OP_SECT_ERASE);
    chk(m.mode, m.M_WIN);
    wr(`NFEC_REG_SECTOR, 32'h00028000);
    op(`NFEC_OP_ADD_SECTOR);
    chk(m.sel[5], 1'b1);
    rd(`NFEC_REG_STATUS, q);
    chk(q[`NFEC_ST_WIN_EXP], 1'b0);
    repeat (2 * WIN_CYC) @(posedge clk);
    rd(`NFEC_REG_STATUS, q);
    chk(q[`NFEC_ST_WIN_EXP], 1'b1);
    fread(22'h018000, q);
    chk(q[7], 1'b0);
    op(`NFEC_OP_SUSPEND);
    chk(m.mode, m.M_SUS);
    fread(22'h018000, q);
    chk(q[7], 1'b1);
    rd(`NFEC_REG_STATUS, q);
    chk(q[`NFEC_ST_POLL], 1'b1);
    fread(22'h000010, q);
    chk(q[15:0], 16'ha5b5);
    op(`NFEC_OP_AUTOSEL);
    fread(22'h000000, q);
    chk(q[15:0], m.MFR_ID);
    op(`NFEC_OP_RESET);
    op(`NFEC_OP_PROGRAM);
    chk(m.mode, m.M_SUS);
    op(`NFEC_OP_RESUME);
    op(`NFEC_OP_RESUME);
    chk(m.mode, m.M_ERS);
    repeat (600) @(posedge clk);
    fread(22'h018000, q);
    chk(q[15:0], 16'h25a5);
    op(`NFEC_OP_SECT_ERASE);
    op(`NFEC_OP_RESET);
    chk(m.mode, m.M_RD);
    op(`NFEC_OP_SECT_ERASE);
    wr(`NFEC_REG_CTRL, 32'h80000000);
    repeat (4) @(posedge clk);
    chk(m.mode, m.M_RD);
    for (int i = 0; i < 5; i++)
    begin
      op(ops[i]);
      chk(m.mode, mds[i]);
    end
    wr(`NFEC_REG_DATA, 32'h00000000);
    op(`NFEC_OP_BUF_START);
    chk(m.bf, 2'h2);
    op(`NFEC_OP_BUF_COMMIT);
    chk(m.bf, 2'h0);
    wrap_up();
  end

  // cut a hang short
  initial
  begin
    #500000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_top
